//--- core/aao_cfg.svh
// Constants for the accumulator add/AND datapath: register offsets, fields, codes, reset values.
// Assumes a single AHB-Lite slave decoding the low byte of haddr.
`ifndef AAO_CFG_SVH
`define AAO_CFG_SVH

// ==========================================
// Register byte offsets
`define AAO_OFF_ACC 8'h00
`define AAO_OFF_STATUS 8'h04
`define AAO_OFF_CMD 8'h08
`define AAO_MEM_SEL 2'b01

// ==========================================
// Command word fields
`define AAO_CMD_OP_HI 1
`define AAO_CMD_OP_LO 0
`define AAO_CMD_IDX_HI 7
`define AAO_CMD_IDX_LO 4
`define AAO_CMD_IMM_HI 15
`define AAO_CMD_IMM_LO 8

// ==========================================
// Operation codes
`define AAO_OP_ADD_MEM 2'h0
`define AAO_OP_ANDA 2'h1
`define AAO_OP_ANDI 2'h2
`define AAO_OP_AND_MEM 2'h3

// ==========================================
// Status flag bit positions
`define AAO_FLG_C 0
`define AAO_FLG_AUX 1
`define AAO_FLG_Z 2
`define AAO_FLG_OVF 3
`define AAO_FLG_SIGN 4

// ==========================================
// Reset values
`define AAO_RST_ACC 8'h00
`define AAO_RST_FLAGS 5'h00
`define AAO_RST_CMD 16'h0000
`define AAO_RST_BYTE 8'h00
`define AAO_RST_WORD 32'h0000_0000
`define AAO_HI_ZERO 24'h00_0000

`endif

//--- core/aao_core.sv
// Accumulator, status flags and a 16-byte data memory with add/AND operations, behind AHB-Lite.
// Assumes one AHB-Lite master, single word transfers, hclk 40 MHz, hresetn asynchronous active low.
// Function
// - Add-to-memory sums the accumulator and the addressed memory byte and writes the sum into that byte.
// - Add-to-memory takes the accumulator and the memory byte as addends and updates overflow, zero, aux carry, carry and signed carry.
// - AND-memory-into-accumulator forms the bitwise AND of the accumulator and the addressed memory byte.
// - AND-memory-into-accumulator writes the accumulator, leaves memory unchanged and touches only the zero flag.
// - AND-immediate ANDs the accumulator with the immediate, writes the accumulator and touches only the zero flag.
// - The AND operations aimed at the accumulator store their result in the accumulator register.
// - AND-to-memory ANDs the addressed memory byte with the accumulator and stores the result in that byte.
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`include "aao_cfg.svh"

module aao_core
    import aao_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    aao_state_s st_reg;
    aao_state_s st_next;

    logic exec;
    logic [1:0] op;
    logic [3:0] idx;
    logic [7:0] imm;
    logic [7:0] mbyte;
    logic [8:0] sum9;
    logic [4:0] lo5;
    logic [7:0] lo8;
    logic [7:0] and_m;
    logic [7:0] and_i;
    logic [7:0] res;
    logic ovf;
    logic [31:0] rd_mux;

    // ==========================================
    // Operands and arithmetic
    assign op = hwdata[`AAO_CMD_OP_HI:`AAO_CMD_OP_LO];
    assign idx = hwdata[`AAO_CMD_IDX_HI:`AAO_CMD_IDX_LO];
    assign imm = hwdata[`AAO_CMD_IMM_HI:`AAO_CMD_IMM_LO];
    assign mbyte = st_reg.mem[idx];
    assign sum9 = {1'b0, st_reg.acc} + {1'b0, mbyte};
    assign lo5 = {1'b0, st_reg.acc[3:0]} + {1'b0, mbyte[3:0]};
    assign lo8 = {1'b0, st_reg.acc[6:0]} + {1'b0, mbyte[6:0]};
    // Carry into bit 7 against carry out of bit 7
    assign ovf = lo8[7] ^ sum9[8];
    assign and_m = st_reg.acc & mbyte;
    assign and_i = st_reg.acc & imm;
    // A command runs in the data phase of a write to CMD, so hwdata carries it
    assign exec = (st_reg.ph == PH_WRITE) && st_reg.hit && (st_reg.addr == `AAO_OFF_CMD);

    always_comb begin
        unique case (op)
            `AAO_OP_ADD_MEM: res = sum9[7:0];
            `AAO_OP_ANDI: res = and_i;
            default: res = and_m;
        endcase
    end

    // ==========================================
    // Read multiplexer
    always_comb begin
        rd_mux = `AAO_RST_WORD;
        if (st_reg.hit) begin
            if (st_reg.addr == `AAO_OFF_ACC) begin
                rd_mux = {`AAO_HI_ZERO, st_reg.acc};
            end else if (st_reg.addr == `AAO_OFF_STATUS) begin
                rd_mux = {27'h000_0000, st_reg.flags};
            end else if (st_reg.addr == `AAO_OFF_CMD) begin
                rd_mux = {16'h0000, st_reg.cmd};
            end else if (st_reg.addr[7:6] == `AAO_MEM_SEL) begin
                rd_mux = {`AAO_HI_ZERO, st_reg.mem[st_reg.addr[5:2]]};
            end
        end
    end

    // ==========================================
    // Next state
    always_comb begin
        st_next = st_reg;
        if (exec) begin
            st_next.cmd = hwdata[15:0];
            st_next.flags[`AAO_FLG_Z] = (res == 8'h00);
            unique case (op)
                `AAO_OP_ADD_MEM: begin
                    st_next.mem[idx] = sum9[7:0];
                    st_next.flags[`AAO_FLG_C] = sum9[8];
                    st_next.flags[`AAO_FLG_AUX] = lo5[4];
                    st_next.flags[`AAO_FLG_OVF] = ovf;
                    // Signed carry is the true sign of the nine-bit signed sum
                    st_next.flags[`AAO_FLG_SIGN] = ovf ^ sum9[7];
                end
                // The AND forms leave every flag but zero alone
                `AAO_OP_ANDA: st_next.acc = and_m;
                `AAO_OP_ANDI: st_next.acc = and_i;
                `AAO_OP_AND_MEM: st_next.mem[idx] = and_m;
            endcase
        end else if ((st_reg.ph == PH_WRITE) && st_reg.hit) begin
            if (st_reg.addr == `AAO_OFF_ACC) begin
                st_next.acc = hwdata[7:0];
            end else if (st_reg.addr == `AAO_OFF_STATUS) begin
                st_next.flags = hwdata[4:0];
            end else if (st_reg.addr[7:6] == `AAO_MEM_SEL) begin
                st_next.mem[st_reg.addr[5:2]] = hwdata[7:0];
            end
        end
        // One wait state on reads so a write just before is always seen
        if (st_reg.ph == PH_RWAIT) begin
            st_next.rdata = rd_mux;
            st_next.ph = PH_RDONE;
        end else if (hsel && hready && htrans[1]) begin
            st_next.addr = haddr[7:0];
            st_next.hit = (haddr[31:8] == `AAO_HI_ZERO);
            st_next.ph = hwrite ? PH_WRITE : PH_RWAIT;
        end else begin
            st_next.ph = PH_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg.ph <= PH_IDLE;
            st_reg.hit <= 1'b0;
            st_reg.addr <= `AAO_RST_BYTE;
            st_reg.acc <= `AAO_RST_ACC;
            st_reg.flags <= `AAO_RST_FLAGS;
            st_reg.cmd <= `AAO_RST_CMD;
            st_reg.mem <= '0;
            st_reg.rdata <= `AAO_RST_WORD;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = (st_reg.ph != PH_RWAIT);
    assign hresp = 1'b0;
    assign hrdata = st_reg.rdata;

    // ==========================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Expectations are rebuilt from the operands, not taken from res or the flag nets
    a_add_mem_sum: assert property (exec && op == `AAO_OP_ADD_MEM |=>
        st_reg.mem[$past(idx)] == 8'($past(st_reg.acc) + $past(mbyte)))
        else $error("add result not stored in memory");
    a_add_carry_flags: assert property (exec && op == `AAO_OP_ADD_MEM |=>
        st_reg.flags[`AAO_FLG_C] == ($past(st_reg.acc) > ~$past(mbyte))
        && st_reg.flags[`AAO_FLG_AUX] == ($past(st_reg.acc[3:0]) > ~$past(mbyte[3:0]))
        && st_reg.acc == $past(st_reg.acc))
        else $error("add carry flags or accumulator wrong");
    // Overflow is a sign change from like-signed addends; the true sign is then the addends' sign
    a_add_sign_flags: assert property (exec && op == `AAO_OP_ADD_MEM |=>
        st_reg.flags[`AAO_FLG_OVF] == ($past(st_reg.acc[7]) == $past(mbyte[7])
        && st_reg.mem[$past(idx)][7] != $past(st_reg.acc[7]))
        && st_reg.flags[`AAO_FLG_SIGN] == (st_reg.flags[`AAO_FLG_OVF] ? $past(st_reg.acc[7])
        : st_reg.mem[$past(idx)][7]))
        else $error("add overflow or sign flag wrong");
    a_anda_and_value: assert property (exec && op == `AAO_OP_ANDA |=>
        st_reg.acc == ($past(st_reg.acc) & $past(mbyte))) else $error("memory AND value wrong");
    a_anda_side_free: assert property (exec && op == `AAO_OP_ANDA |=>
        st_reg.mem == $past(st_reg.mem)
        && st_reg.flags[`AAO_FLG_C] == $past(st_reg.flags[`AAO_FLG_C])
        && st_reg.flags[`AAO_FLG_AUX] == $past(st_reg.flags[`AAO_FLG_AUX])
        && st_reg.flags[`AAO_FLG_OVF] == $past(st_reg.flags[`AAO_FLG_OVF])
        && st_reg.flags[`AAO_FLG_SIGN] == $past(st_reg.flags[`AAO_FLG_SIGN]))
        else $error("memory AND disturbed other state");
    a_andi_only_zero: assert property (exec && op == `AAO_OP_ANDI |=>
        st_reg.acc == ($past(st_reg.acc) & $past(imm))
        && st_reg.mem == $past(st_reg.mem)
        && st_reg.flags[`AAO_FLG_C] == $past(st_reg.flags[`AAO_FLG_C])
        && st_reg.flags[`AAO_FLG_AUX] == $past(st_reg.flags[`AAO_FLG_AUX])
        && st_reg.flags[`AAO_FLG_OVF] == $past(st_reg.flags[`AAO_FLG_OVF])
        && st_reg.flags[`AAO_FLG_SIGN] == $past(st_reg.flags[`AAO_FLG_SIGN]))
        else $error("immediate AND wrong");
    a_and_to_acc: assert property (exec && (op == `AAO_OP_ANDA || op == `AAO_OP_ANDI) |=>
        st_reg.acc == ($past(st_reg.acc)
        & ($past(op) == `AAO_OP_ANDI ? $past(imm) : $past(mbyte))))
        else $error("AND result not in accumulator");
    a_and_mem_dest: assert property (exec && op == `AAO_OP_AND_MEM |=>
        st_reg.mem[$past(idx)] == ($past(mbyte) & $past(st_reg.acc)) && st_reg.acc == $past(st_reg.acc))
        else $error("AND to memory wrong");
    a_and_mem_flags: assert property (exec && op == `AAO_OP_AND_MEM |=>
        st_reg.flags[`AAO_FLG_C] == $past(st_reg.flags[`AAO_FLG_C])
        && st_reg.flags[`AAO_FLG_AUX] == $past(st_reg.flags[`AAO_FLG_AUX])
        && st_reg.flags[`AAO_FLG_OVF] == $past(st_reg.flags[`AAO_FLG_OVF])
        && st_reg.flags[`AAO_FLG_SIGN] == $past(st_reg.flags[`AAO_FLG_SIGN]))
        else $error("AND to memory disturbed flags");
    // Zero is judged on the byte that was actually stored, wherever it went
    a_zero_flag_set: assert property (exec |=>
        st_reg.flags[`AAO_FLG_Z] == ((($past(op) == `AAO_OP_ADD_MEM || $past(op) == `AAO_OP_AND_MEM)
        ? st_reg.mem[$past(idx)] : st_reg.acc) == 8'h00))
        else $error("zero flag wrong");
    a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_unmapped_zero: assert property (st_reg.ph == PH_RWAIT && !st_reg.hit |=>
        hrdata == `AAO_RST_WORD) else $error("unmapped read not zero");
    a_acc_held_idle: assert property (!exec
        && !((st_reg.ph == PH_WRITE) && st_reg.hit && (st_reg.addr == `AAO_OFF_ACC))
        |=> st_reg.acc == $past(st_reg.acc))
        else $error("accumulator changed without a command or write");

    c_add_carry: cover property (exec && op == `AAO_OP_ADD_MEM && sum9[8]);
    c_anda_zero: cover property (exec && op == `AAO_OP_ANDA && res == 8'h00);
    c_andi_zero: cover property (exec && op == `AAO_OP_ANDI && res == 8'h00);
    c_and_mem_run: cover property (exec && op == `AAO_OP_AND_MEM);
    c_read_done: cover property (st_reg.ph == PH_RDONE);

endmodule : aao_core

//--- core/aao_pkg.sv
// Types shared by the accumulator add/AND datapath.
// Assumes aao_cfg.svh is compiled alongside.
package aao_pkg;

    // ==========================================
    // Bus data phase tracking
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_RWAIT,
        PH_RDONE
    } aao_ph_e;

    // ==========================================
    // Whole state of the block
    typedef struct packed {
        aao_ph_e ph;
        logic hit;
        logic [7:0] addr;
        logic [7:0] acc;
        logic [4:0] flags;
        logic [15:0] cmd;
        logic [15:0][7:0] mem;
        logic [31:0] rdata;
    } aao_state_s;

endpackage : aao_pkg

//--- dv/tb_top.sv
// Self-checking bench for the accumulator add/AND datapath, reached only over AHB-Lite.
// Assumes aao_pkg and aao_cfg.svh are compiled first; the bench drives every design input but hready, which is tied to hreadyout.
`include "aao_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aao_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] acc_m, mem_m [16];
    logic [4:0] flg_m;
    int num_errors, total_checks, seed, k, i;
    int cyc = 0;
    logic [31:0] ra, rb;
    logic [23:0] hi_addr = 24'h00_0000;
    logic [7:0] ca [6] = '{8'hff, 8'h7f, 8'h80, 8'h0f, 8'h00, 8'h55};
    logic [7:0] cb [6] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'h00, 8'haa};
    // ==========================================
    // Design and clock
    aao_core u_aao_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        // Far above the roughly 1700 cycles the sequence needs
        if (cyc == 40000) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end
    // ==========================================
    // Bus tasks and comparison
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Ready is looked at on the falling edge, where it is settled for the coming rising edge
    task wait_rdy();
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            @(negedge hclk);
        end
    endtask : wait_rdy
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'b10;
        haddr <= {hi_addr, a};
        hwrite <= w;
        wait_rdy();
        @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        @(posedge hclk);
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, a, wd, rd);
    endtask : wr
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(nm, exp, rd);
    endtask : rchk
    // ==========================================
    // Operation model and run
    task run_op(input logic [1:0] op, input logic [3:0] ix, input logic [7:0] im, input logic [7:0] a,
        input logic [7:0] m, input logic [4:0] f);
        logic [8:0] s;
        logic [7:0] r, ma;
        ma = 8'h40 + {2'b00, ix, 2'b00};
        wr(`AAO_OFF_ACC, {24'h00_0000, a});
        wr(ma, {24'h00_0000, m});
        wr(`AAO_OFF_STATUS, {27'h0, f});
        acc_m = a;
        flg_m = f;
        mem_m[ix] = m;
        case (op)
            `AAO_OP_ADD_MEM: begin
                s = {1'b0, a} + {1'b0, m};
                r = s[7:0];
                mem_m[ix] = r;
                flg_m[`AAO_FLG_C] = s[8];
                flg_m[`AAO_FLG_AUX] = ({1'b0, a[3:0]} + {1'b0, m[3:0]}) > 5'h0f;
                flg_m[`AAO_FLG_OVF] = s[8] ^ (({1'b0, a[6:0]} + {1'b0, m[6:0]}) > 8'h7f);
                flg_m[`AAO_FLG_SIGN] = flg_m[`AAO_FLG_OVF] ^ r[7];
            end
            `AAO_OP_ANDA: begin
                r = a & m;
                acc_m = r;
            end
            `AAO_OP_ANDI: begin
                r = a & im;
                acc_m = r;
            end
            default: begin
                r = a & m;
                mem_m[ix] = r;
            end
        endcase
        flg_m[`AAO_FLG_Z] = (r == 8'h00);
        wr(`AAO_OFF_CMD, {16'h0000, im, ix, 2'b00, op});
        rchk("acc", `AAO_OFF_ACC, {24'h00_0000, acc_m});
        rchk("status", `AAO_OFF_STATUS, {27'h0, flg_m});
        rchk("memory", ma, {24'h00_0000, mem_m[ix]});
        rchk("cmd", `AAO_OFF_CMD, {16'h0000, im, ix, 2'b00, op});
    endtask : run_op
    task give_verdict();
        $display("Checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        {num_errors, total_checks} = '0;
        seed = 29;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        rchk("acc reset", `AAO_OFF_ACC, `AAO_RST_WORD);
        rchk("status reset", `AAO_OFF_STATUS, `AAO_RST_WORD);
        rchk("memory reset", 8'h7c, `AAO_RST_WORD);
        rchk("unmapped", 8'hf0, `AAO_RST_WORD);
        // Carry, half carry, overflow and zero boundaries through every operation
        for (k = 0; k < 6; k++) begin
            for (i = 0; i < 4; i++) begin
                run_op(i[1:0], k[3:0], cb[k], ca[k], cb[k], 5'h1f ^ k[4:0]);
            end
        end
        // Upper address bits set: the write must be ignored and the read must return zero
        hi_addr = 24'h00_0001;
        wr(`AAO_OFF_ACC, 32'h0000_00a5);
        rchk("unmapped high", `AAO_OFF_ACC, `AAO_RST_WORD);
        hi_addr = 24'h00_0000;
        rchk("acc kept", `AAO_OFF_ACC, {24'h00_0000, acc_m});
        for (k = 0; k < 60; k++) begin
            ra = $random(seed);
            rb = $random(seed);
            run_op(ra[1:0], ra[7:4], ra[15:8], ra[23:16], ra[31:24], rb[4:0]);
        end
        give_verdict();
    end
endmodule : tb_top
